// ### rtl/ckss_clock_switch.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Summary of operation
// - pll start writes are ignored unless fallback bit is zero.
// - pll start with fallback clear starts pll and selects it for core.
// - pll start locks clock config; writing zero unlocks without switching.
// - fallback bit selects osc for core, stops pll and stops core clock.
// - fallback enters light sleep only while supply-good is zero.
// - metering clock runs after reset, stops while its gate bit is set.
// - display gate stops display clock only when pll feeds core and meter.
// - with supply-good zero and core source osc, codes 01/11 give light sleep.
// - under the same conditions with fallback clear, code 10 gives deep sleep.
// - core source bit selects osc/pll and reads back source in use.
// - wakeup without reset clears only sleep field, pll start and fallback.
// - state register read-only; top reset flag set by level-one reset.
// - pin wakeup flag set when io event ends either sleep state.
// - timer/pulse flag set on light-sleep wakeup; pulse detect tells which.
// - power-down flag one below lower threshold, zero above upper.
// - supply-good flag one above upper threshold, zero below lower.
// - wake-mode bit set makes any wakeup resume without reset.
// - metering source bit selects osc/pll and reads back source.
module ckss_clock_switch
  import ckss_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  output logic [7:0]      sfr_rdata_out,
  input  wire logic       top_reset_cause_in,
  input  wire logic       supply_above_upper_in,
  input  wire logic       supply_below_lower_in,
  input  wire logic       wake_without_reset_in,
  input  wire logic       pin_wake_event_in,
  input  wire logic       timer_wake_event_in,
  input  wire logic       pulse_wake_event_in,
  input  wire logic       supply_restore_in,
  output logic            wake_reset_req_out,
  output logic            pll_enable_out,
  output logic            core_clock_pll_out,
  output logic            core_clock_en_out,
  output logic            aux_clock_en_out,
  output logic            meter_clock_pll_out,
  output logic            meter_clock_en_out,
  output logic            display_clock_en_out,
  output logic            power_down_irq_out,
  output logic            light_sleep_out,
  output logic            deep_sleep_out,
  output logic            pulse_wake_detect_out
);
  // ==========================================================================
  // control register
  ckss_sfr_if sfr ();
  logic [7:0] ctrl;
  logic       ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic       fallback_ok;
  logic       locked;
  logic       start_wr;

  assign ctrl_wr     = sfr_wr_in && (sfr_addr_in == CKSS_CTRL_ADDR);
  assign ctrl        = sfr.ctrl;
  assign fallback_ok = !ctrl[CKSS_FALLBACK_BIT];
  assign locked      = ctrl[CKSS_PLL_START_BIT];
  // pll start bit is only writable with fallback clear
  assign start_wr    = fallback_ok ? sfr_wdata_in[CKSS_PLL_START_BIT] : ctrl[CKSS_PLL_START_BIT];

  // while locked, the source selects are frozen except a fallback write clears core source; a start write while unlocked also forces pll for core
  always_comb begin
    ctrl_wdata = sfr_wdata_in;
    ctrl_wdata[CKSS_PLL_START_BIT] = start_wr;
    if (locked) begin
      ctrl_wdata[CKSS_CORE_SRC_BIT]  = ctrl[CKSS_CORE_SRC_BIT];
      ctrl_wdata[CKSS_METER_SRC_BIT] = ctrl[CKSS_METER_SRC_BIT];
    end
    if (start_wr && !locked) begin
      ctrl_wdata[CKSS_CORE_SRC_BIT] = 1'b1;
    end
    if (sfr_wdata_in[CKSS_FALLBACK_BIT]) begin
      ctrl_wdata[CKSS_CORE_SRC_BIT] = 1'b0;
    end
  end

  assign sfr.wr_en   = ctrl_wr;
  assign sfr.wr_data = ctrl_wdata;

  ckss_ctrl_reg u_ctrl (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .bus      (sfr)
  );

  // ==========================================================================
  // supply flags with hysteresis
  logic supply_ok_reg;
  logic power_down_reg;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      supply_ok_reg  <= CKSS_STATE_RESET[CKSS_SUPPLY_OK_BIT];
      power_down_reg <= CKSS_STATE_RESET[CKSS_PWR_DOWN_BIT];
    end else if (supply_above_upper_in) begin
      supply_ok_reg  <= 1'b1;
      power_down_reg <= 1'b0;
    end else if (supply_below_lower_in) begin
      supply_ok_reg  <= 1'b0;
      power_down_reg <= 1'b1;
    end
    // between thresholds both hold
  end
  // interrupt enable lives in the interrupt controller outside
  assign power_down_irq_out = power_down_reg;

  // ==========================================================================
  // sleep state machine
  ckss_power_type power_reg;
  ckss_power_type power_next;
  logic [1:0]     sleep_code;
  logic           light_req;
  logic           deep_req;
  logic           wake_light;
  logic           wake_deep;
  logic           wake_any;

  assign sleep_code = {ctrl[CKSS_SLEEP_HI_BIT], ctrl[CKSS_SLEEP_LO_BIT]};
  // firmware must clear core source first; the gate also checks it
  assign light_req  = !supply_ok_reg && !ctrl[CKSS_CORE_SRC_BIT] &&
                      ((sleep_code == CKSS_SLEEP_LIGHT_A) || (sleep_code == CKSS_SLEEP_LIGHT_B) ||
                       ctrl[CKSS_FALLBACK_BIT]);
  assign deep_req   = !supply_ok_reg && !ctrl[CKSS_CORE_SRC_BIT] && !ctrl[CKSS_FALLBACK_BIT] &&
                      (sleep_code == CKSS_SLEEP_DEEP);
  assign wake_light = pin_wake_event_in || timer_wake_event_in || pulse_wake_event_in || supply_restore_in;
  assign wake_deep  = pin_wake_event_in || supply_restore_in;
  assign wake_any   = ((power_reg == CKSS_LIGHT) && wake_light) || ((power_reg == CKSS_DEEP) && wake_deep);

  always_comb begin
    case (power_reg)
      CKSS_RUN: begin
        power_next = deep_req ? CKSS_DEEP : (light_req ? CKSS_LIGHT : CKSS_RUN);
      end
      CKSS_LIGHT: begin
        power_next = wake_light ? CKSS_RUN : CKSS_LIGHT;
      end
      CKSS_DEEP: begin
        power_next = wake_deep ? CKSS_RUN : CKSS_DEEP;
      end
      default: begin
        power_next = CKSS_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      power_reg <= CKSS_RUN;
    end else begin
      power_reg <= power_next;
    end
  end

  // retained wakeup clears the sleep request bits; otherwise system reset
  assign sfr.wake_clear     = wake_any && wake_without_reset_in;
  assign wake_reset_req_out = wake_any && !wake_without_reset_in;

  // ==========================================================================
  // wakeup cause and reset flags
  logic top_reset_reg;
  logic pin_wake_reg;
  logic timer_wake_reg;
  logic pulse_seen_reg;
  logic top_reset_seen;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      top_reset_seen <= 1'b0;
      top_reset_reg  <= CKSS_STATE_RESET[CKSS_TOP_RESET_BIT];
    end else if (!top_reset_seen) begin
      // cause strap caught once after release
      top_reset_seen <= 1'b1;
      top_reset_reg  <= top_reset_cause_in;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_wake_reg   <= CKSS_STATE_RESET[CKSS_PIN_WAKE_BIT];
      timer_wake_reg <= CKSS_STATE_RESET[CKSS_TIMER_WAKE_BIT];
      pulse_seen_reg <= 1'b0;
    end else if (wake_any) begin
      pin_wake_reg   <= pin_wake_event_in;
      timer_wake_reg <= (power_reg == CKSS_LIGHT) && (timer_wake_event_in || pulse_wake_event_in);
      pulse_seen_reg <= (power_reg == CKSS_LIGHT) && pulse_wake_event_in;
    end
  end

  // ==========================================================================
  // clock outputs
  logic sleeping;
  assign sleeping             = (power_reg != CKSS_RUN);
  assign pll_enable_out       = ctrl[CKSS_PLL_START_BIT] && !ctrl[CKSS_FALLBACK_BIT];
  assign core_clock_pll_out   = ctrl[CKSS_CORE_SRC_BIT];
  assign core_clock_en_out    = !sleeping && !ctrl[CKSS_FALLBACK_BIT];
  assign aux_clock_en_out     = !sleeping;
  assign meter_clock_pll_out  = ctrl[CKSS_METER_SRC_BIT];
  assign meter_clock_en_out   = !ctrl[CKSS_METER_GATE_BIT];
  assign display_clock_en_out = !(ctrl[CKSS_DISP_GATE_BIT] && ctrl[CKSS_CORE_SRC_BIT] &&
                                  ctrl[CKSS_METER_SRC_BIT]);
  assign light_sleep_out      = (power_reg == CKSS_LIGHT);
  assign deep_sleep_out       = (power_reg == CKSS_DEEP);
  // pulse detect lives in the wakeup detect register outside, so it leaves as a pin
  assign pulse_wake_detect_out = pulse_seen_reg;

  // ==========================================================================
  // read data: state register ignores writes
  logic [7:0] state_word;
  always_comb begin
    state_word = CKSS_STATE_RESET;
    state_word[CKSS_TOP_RESET_BIT]  = top_reset_reg;
    state_word[CKSS_PIN_WAKE_BIT]   = pin_wake_reg;
    state_word[CKSS_TIMER_WAKE_BIT] = timer_wake_reg;
    state_word[CKSS_PWR_DOWN_BIT]   = power_down_reg;
    state_word[CKSS_SUPPLY_OK_BIT]  = supply_ok_reg;
  end
  assign sfr_rdata_out = (sfr_addr_in == CKSS_CTRL_ADDR)  ? ctrl :
                         (sfr_addr_in == CKSS_STATE_ADDR) ? state_word : 8'h00;

  // ==========================================================================
  // checks
  a_start_blocked: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl[CKSS_FALLBACK_BIT] && !ctrl[CKSS_PLL_START_BIT] |=> !ctrl[CKSS_PLL_START_BIT])
    else $error("pll start set while fallback active");
  a_start_selects_pll: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_wr && fallback_ok && !locked && sfr_wdata_in[CKSS_PLL_START_BIT] && !sfr_wdata_in[CKSS_FALLBACK_BIT]
    && !sfr.wake_clear |=> ctrl[CKSS_CORE_SRC_BIT] && pll_enable_out)
    else $error("pll start did not select pll");
  a_lock_holds_src: assert property (@(posedge clock_in) disable iff (!nrst_in)
    locked && !sfr_wdata_in[CKSS_FALLBACK_BIT] |=> $stable(ctrl[CKSS_METER_SRC_BIT]))
    else $error("source changed while locked");
  a_fallback_stops: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl[CKSS_FALLBACK_BIT] |-> !core_clock_en_out && !pll_enable_out && !core_clock_pll_out)
    else $error("fallback left core or pll running");
  a_no_sleep_mains: assert property (@(posedge clock_in) disable iff (!nrst_in)
    power_reg == CKSS_RUN && supply_ok_reg |=> power_reg == CKSS_RUN)
    else $error("sleep entered with supply good");
  a_meter_gate: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_wr && sfr_wdata_in[CKSS_METER_GATE_BIT] |=> !meter_clock_en_out)
    else $error("metering clock not gated");
  a_display_gate: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !core_clock_pll_out |-> display_clock_en_out)
    else $error("display stopped without pll source");
  a_deep_entry: assert property (@(posedge clock_in) disable iff (!nrst_in)
    power_reg == CKSS_RUN && deep_req |=> deep_sleep_out && !aux_clock_en_out)
    else $error("deep sleep not entered");
  a_wake_clears: assert property (@(posedge clock_in) disable iff (!nrst_in)
    sfr.wake_clear |=> (ctrl & CKSS_WAKE_CLEAR_MASK) == 8'h00 && power_reg == CKSS_RUN)
    else $error("retained wakeup left sleep bits");
  a_supply_flags: assert property (@(posedge clock_in) disable iff (!nrst_in)
    supply_above_upper_in |=> supply_ok_reg && !power_down_reg)
    else $error("supply flags wrong above threshold");
  a_hysteresis: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !supply_above_upper_in && !supply_below_lower_in |=> $stable(supply_ok_reg))
    else $error("supply flag moved between thresholds");
  a_fallback_light: assert property (@(posedge clock_in) disable iff (!nrst_in)
    power_reg == CKSS_RUN && ctrl[CKSS_FALLBACK_BIT] && !supply_ok_reg |=> light_sleep_out)
    else $error("fallback did not enter light sleep");
  a_fallback_not_deep: assert property (@(posedge clock_in) disable iff (!nrst_in)
    power_reg == CKSS_RUN && ctrl[CKSS_FALLBACK_BIT] |=> !deep_sleep_out)
    else $error("fallback entered deep sleep");
  a_light_entry: assert property (@(posedge clock_in) disable iff (!nrst_in)
    power_reg == CKSS_RUN && light_req && !deep_req
    |=> light_sleep_out && !core_clock_en_out && !aux_clock_en_out)
    else $error("light sleep not entered");
  a_core_src_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    sfr_addr_in == CKSS_CTRL_ADDR |-> sfr_rdata_out[CKSS_CORE_SRC_BIT] == core_clock_pll_out)
    else $error("core source readback differs");
  a_top_flag_kept: assert property (@(posedge clock_in) disable iff (!nrst_in)
    top_reset_seen |=> $stable(top_reset_reg))
    else $error("top reset flag changed");
  a_pin_wake_flag: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wake_any && pin_wake_event_in |=> pin_wake_reg)
    else $error("pin wakeup flag not set");
  a_timer_wake_flag: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wake_any && (power_reg == CKSS_LIGHT) && (timer_wake_event_in || pulse_wake_event_in) |=> timer_wake_reg)
    else $error("timer wakeup flag not set");
  a_pulse_detect: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wake_any && (power_reg == CKSS_LIGHT) && pulse_wake_event_in |=> pulse_wake_detect_out)
    else $error("pulse wakeup not detected");
  a_deep_no_timer: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wake_any && (power_reg == CKSS_DEEP) |=> !timer_wake_reg && !pulse_wake_detect_out)
    else $error("timer flag set on deep wakeup");
  a_power_down: assert property (@(posedge clock_in) disable iff (!nrst_in)
    supply_below_lower_in && !supply_above_upper_in |=> power_down_irq_out && !supply_ok_reg)
    else $error("supply flags wrong below threshold");
  a_wake_resets: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wake_any && !wake_without_reset_in |-> wake_reset_req_out && !sfr.wake_clear)
    else $error("wakeup with reset not requested");
  a_lock_core_src: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_wr && locked && !sfr_wdata_in[CKSS_FALLBACK_BIT] |=> $stable(core_clock_pll_out))
    else $error("core source changed while locked");
  a_fallback_osc: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_wr && sfr_wdata_in[CKSS_FALLBACK_BIT] |=> !core_clock_pll_out && !pll_enable_out)
    else $error("fallback write left pll selected");
  a_meter_src_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_wr && !locked |=> meter_clock_pll_out == $past(sfr_wdata_in[CKSS_METER_SRC_BIT]))
    else $error("metering source not taken from write");
endmodule
`default_nettype wire

// ### rtl/ckss_pkg.sv
package ckss_pkg;
  // ===========================================================================
  // register offsets (special-function addresses)
  localparam logic [7:0] CKSS_CTRL_ADDR  = 8'h80;
  localparam logic [7:0] CKSS_STATE_ADDR = 8'ha1;
  // ===========================================================================
  // control register fields
  localparam int CKSS_METER_SRC_BIT  = 7;
  localparam int CKSS_PLL_START_BIT  = 6;
  localparam int CKSS_FALLBACK_BIT   = 5;
  localparam int CKSS_METER_GATE_BIT = 4;
  localparam int CKSS_DISP_GATE_BIT  = 3;
  localparam int CKSS_SLEEP_HI_BIT   = 2;
  localparam int CKSS_SLEEP_LO_BIT   = 1;
  localparam int CKSS_CORE_SRC_BIT   = 0;
  localparam logic [7:0] CKSS_CTRL_RESET = 8'h00;
  // bits cleared on a wakeup that keeps state
  localparam logic [7:0] CKSS_WAKE_CLEAR_MASK = 8'h66;
  // ===========================================================================
  // state register fields
  localparam int CKSS_TOP_RESET_BIT  = 5;
  localparam int CKSS_PIN_WAKE_BIT   = 3;
  localparam int CKSS_TIMER_WAKE_BIT = 2;
  localparam int CKSS_PWR_DOWN_BIT   = 1;
  localparam int CKSS_SUPPLY_OK_BIT  = 0;
  localparam logic [7:0] CKSS_STATE_RESET = 8'h00;
  // ===========================================================================
  // sleep field codes
  localparam logic [1:0] CKSS_SLEEP_LIGHT_A = 2'h1;
  localparam logic [1:0] CKSS_SLEEP_LIGHT_B = 2'h3;
  localparam logic [1:0] CKSS_SLEEP_DEEP    = 2'h2;
  // nominal pll output, documentation only: the pll itself is analog
  localparam int CKSS_PLL_FREQ_HZ = 3276800;

  typedef enum logic [1:0] {
    CKSS_RUN   = 2'b00,
    CKSS_LIGHT = 2'b01,
    CKSS_DEEP  = 2'b11
  } ckss_power_type;
endpackage

// ### rtl/ckss_sfr_if.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// write port between the top and the wakeup-clear stage
interface ckss_sfr_if;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       wake_clear;
  logic [7:0] ctrl;
  modport owner (input wr_en, input wr_data, input wake_clear, output ctrl);
  modport user  (output wr_en, output wr_data, output wake_clear, input ctrl);
endinterface
`default_nettype wire

// ### rtl/ckss_ctrl_reg.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// control register storage: software write, wakeup clear
module ckss_ctrl_reg
  import ckss_pkg::*;
(
  input  wire logic   clock_in,
  input  wire logic   nrst_in,
  ckss_sfr_if.owner   bus
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  // a wakeup in the same cycle as a write still clears the sleep bits
  assign ctrl_next = bus.wake_clear ? ((bus.wr_en ? bus.wr_data : ctrl_reg) & ~CKSS_WAKE_CLEAR_MASK)
                                    : (bus.wr_en ? bus.wr_data : ctrl_reg);
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg <= CKSS_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end
  assign bus.ctrl = ctrl_reg;
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import ckss_pkg::*;
;
  // ===========================================================================
  // stimulus signals
  logic        clock_in, nrst_in, sfr_wr_in, top_cause, above, below, wake_mode;
  logic        pin_ev, timer_ev, pulse_ev, restore_ev, chk_v, pd;
  logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic        wreq, pll_en, cpll, cen, aux, mpll, men, den, irq, lt, dp, pdet;
  logic [19:0] obs, qv[$], qm[$], e, m;
  logic [31:0] rnd;
  logic [7:0]  v;
  int          n_fail, comparisons;
  assign obs = {pdet, sfr_rdata_out, irq, wreq, mpll, pll_en, cpll, cen, aux, men, den, lt, dp};

  ckss_clock_switch dut (.clock_in(clock_in), .nrst_in(nrst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rdata_out(sfr_rdata_out),
    .top_reset_cause_in(top_cause), .supply_above_upper_in(above), .supply_below_lower_in(below),
    .wake_without_reset_in(wake_mode), .pin_wake_event_in(pin_ev), .timer_wake_event_in(timer_ev),
    .pulse_wake_event_in(pulse_ev), .supply_restore_in(restore_ev), .wake_reset_req_out(wreq),
    .pll_enable_out(pll_en), .core_clock_pll_out(cpll), .core_clock_en_out(cen),
    .aux_clock_en_out(aux), .meter_clock_pll_out(mpll), .meter_clock_en_out(men),
    .display_clock_en_out(den), .power_down_irq_out(irq), .light_sleep_out(lt), .deep_sleep_out(dp),
    .pulse_wake_detect_out(pdet));

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // ===========================================================================
  // drivers: each note goes on the queue as the check is launched
  task automatic chk(input logic [7:0] a, input logic [19:0] ev, input logic [19:0] mk, input logic [1:0] w);
    @(negedge clock_in);
    sfr_addr_in = a;
    {pin_ev, timer_ev} = w;
    chk_v = 1'b1;
    qv.push_back(ev);
    qm.push_back(mk);
    @(negedge clock_in);
    chk_v = 1'b0;
    {pin_ev, timer_ev} = 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(negedge clock_in);
    sfr_wr_in = 1'b0;
  endtask

  // expected clock outputs derived from the control value and sleep state
  task automatic ctl(input logic [7:0] c, input logic l, input logic d);
    chk(8'h80, {1'b0, c, pd, 1'b0, c[7], c[6] & ~c[5], c[0], ~c[5] & ~(l | d), ~(l | d), ~c[4],
        ~(c[3] & c[0] & c[7]), l, d}, 20'h7ffff, 2'b00);
  endtask

  // bit 8 of the expected state is the pulse detect pin
  task automatic st(input logic [8:0] s);
    chk(8'ha1, {s, s[1], 10'h000}, {9'h1ff, 1'b1, 10'h000}, 2'b00);
  endtask

  // w is {pin, timer, pulse, supply restore}
  task automatic pulse(input logic [3:0] w);
    @(negedge clock_in);
    {pin_ev, timer_ev, pulse_ev, restore_ev} = w;
    @(negedge clock_in);
    {pin_ev, timer_ev, pulse_ev, restore_ev} = 4'h0;
    repeat (2) @(negedge clock_in);
  endtask

  task automatic rst(input logic cause);
    nrst_in = 1'b0;
    top_cause = cause;
    repeat (12) @(negedge clock_in);
    nrst_in = 1'b1;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ===========================================================================
  // monitor: oldest note is compared when a check strobe is sampled
  always @(posedge clock_in) begin
    if (chk_v === 1'b1) begin
      e = qv.pop_front();
      m = qm.pop_front();
      comparisons++;
      if ((obs & m) !== (e & m)) begin
        n_fail++;
        $display("wrong value at %0t: got %h expected %h", $time, obs & m, e & m);
      end
    end
  end

  // run is under two hundred cycles; generous margin before giving up
  initial begin
    #(8 * 5000);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    {sfr_wr_in, chk_v, pin_ev, timer_ev, pulse_ev, restore_ev, above, below, pd} = '0;
    sfr_addr_in = 8'h00;
    sfr_wdata_in = 8'h00;
    wake_mode = 1'b1;
    n_fail = 0;
    comparisons = 0;
    rnd = 32'h2605;
    rst(1'b1);
    st(9'h020);
    wr(8'ha1, 8'hff);
    st(9'h020);
    chk(8'h55, 20'h0, {1'b0, 8'hff, 11'h0}, 2'b00);
    ctl(8'h00, 1'b0, 1'b0);
    done("reset");
    repeat (6) begin
      rnd = lfsr(rnd);
      v = rnd[7:0] & 8'h98;
      wr(8'h80, v);
      ctl(v, 1'b0, 1'b0);
    end
    done("meter");
    wr(8'h80, 8'h88);
    ctl(8'h88, 1'b0, 1'b0);
    wr(8'h80, 8'hc8);
    ctl(8'hc9, 1'b0, 1'b0);
    wr(8'h80, 8'h40);
    ctl(8'hc1, 1'b0, 1'b0);
    wr(8'h80, 8'h00);
    ctl(8'h81, 1'b0, 1'b0);
    wr(8'h80, 8'h00);
    done("lock");
    above = 1'b1;
    st(9'h021);
    above = 1'b0;
    st(9'h021);
    wr(8'h80, 8'h20);
    ctl(8'h20, 1'b0, 1'b0);
    wr(8'h80, 8'h60);
    ctl(8'h20, 1'b0, 1'b0);
    wr(8'h80, 8'h00);
    done("fallback");
    below = 1'b1;
    pd = 1'b1;
    st(9'h022);
    below = 1'b0;
    st(9'h022);
    done("supply");
    // light by code, light by code, deep by pin, light by fallback and pulse, deep by supply restore
    for (int i = 0; i < 5; i++) begin
      v = (i == 3) ? 8'h30 : {5'h02, (i == 0) ? CKSS_SLEEP_LIGHT_A : (i == 1) ? CKSS_SLEEP_LIGHT_B
        : CKSS_SLEEP_DEEP, 1'b0};
      wr(8'h80, v);
      repeat (2) @(negedge clock_in);
      ctl(v, i == 0 || i == 1 || i == 3, i == 2 || i == 4);
      pulse((i == 0) ? 4'h4 : (i == 3) ? 4'h2 : (i == 4) ? 4'h1 : 4'h8);
      ctl(8'h10, 1'b0, 1'b0);
      st((i == 0) ? 9'h026 : (i == 3) ? 9'h126 : (i == 4) ? 9'h022 : 9'h02a);
    end
    done("sleep");
    wake_mode = 1'b0;
    wr(8'h80, 8'h04);
    repeat (2) @(negedge clock_in);
    chk(8'h80, 20'h00200, 20'h00200, 2'b10);
    rst(1'b0);
    st(9'h000);
    done("wake reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
